//--- brlp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "brlp_regs.svh"
// Behaviour
// (RULE_01) lift-off or late missing flame restarts capped by own limit, zero to five
// (RULE_02) restart and anti-oscillation counters clear on entering operation or unlock
// (RULE_03) idle air check between lift-off restarts; exhausted without flame locks out
// (RULE_04) open safety chain holds the block in chain-open wait, state 25
// (RULE_05) chain still open after timeout: lockout or restart by anti-oscillation count
// (RULE_06) policy 0 means counted restart, policy 1 means immediate lockout
// (RULE_07) open-chain policy also covers chain opening after sequence state 4
// (RULE_08) general restart limit zero overrides restart policy: no restart
// (RULE_09) air monitoring selectable in start-up 6-10 and operation 13-14, 17-20
// (RULE_10) air monitoring also selectable for idle state control, state 3
// (RULE_11) mask bits: idle, pilot, main, startup, post-aeration, cooling standby
// (RULE_12) general restart limit zero to five; last failed restart gives held lockout
// (RULE_13) chain-open wait lasts the configured timeout before the policy applies

module brlp_top
	import brlp_pkg::*;
#(
	parameter int TICK_CYCLES = `BRLP_TICK_MS * 1000000 / `BRLP_CLK_NS
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pwrite_i,
	input wire logic psel_i,
	input wire logic penable_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// sequencer, same clock
	input wire logic [4:0] seq_state_i,
	input wire logic liftoff_i,
	input wire logic enter_operating_i,
	input wire logic unlock_i,
	// field pins
	input wire logic chain_closed_i,
	input wire logic flame_i,
	input wire logic air_pressure_switch_i,
	// results
	output logic restart_req_o,
	output logic lockout_o,
	output logic chain_wait_o,
	output logic air_check_o,
	output logic air_monitor_o,
	output logic air_fault_o,
	output logic irq_o
);

	localparam logic [25:0] TICK_MAX = 26'(TICK_CYCLES - 1);

	// pin synchronisers
	// idle levels {air, flame, chain}: closed chain must not look like an opening after reset
	localparam logic [2:0] PIN_IDLE = `BRLP_RST_PINS;
	logic [2:0] pin_raw;
	logic [2:0] sync_q1_r;
	logic [2:0] sync_q2_r;
	assign pin_raw = {air_pressure_switch_i, flame_i, chain_closed_i};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				sync_q1_r[i] <= PIN_IDLE[i];
				sync_q2_r[i] <= PIN_IDLE[i];
			end else begin
				sync_q1_r[i] <= pin_raw[i];
				sync_q2_r[i] <= sync_q1_r[i];
			end
		end
	end
	logic chain_ok;
	logic flame_ok;
	logic air_ok;
	assign chain_ok = sync_q2_r[0];
	assign flame_ok = sync_q2_r[1];
	assign air_ok = sync_q2_r[2];

	// tick divider
	logic [25:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;
	always_comb begin
		tick_nxt = (tick_cnt_r == TICK_MAX);
		tick_cnt_nxt = tick_nxt ? 26'h0000000 : tick_cnt_r + 26'h0000001;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_r <= 26'h0000000;
			tick_r <= 1'h0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// registers
	logic [2:0] restart_limit_r, restart_limit_nxt;
	logic [2:0] liftoff_restart_limit_r, liftoff_restart_limit_nxt;
	logic open_chain_policy_r, open_chain_policy_nxt;
	logic [5:0] air_pressure_monitor_mask_r, air_pressure_monitor_mask_nxt;
	logic [15:0] chain_open_timeout_r, chain_open_timeout_nxt;
	logic [3:0] irq_stat_r, irq_stat_nxt;
	logic [3:0] irq_en_r, irq_en_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic irq_r, irq_nxt;

	// sequencing state
	brlp_state_t state_r, state_nxt;
	logic [2:0] rcnt_r, rcnt_nxt;
	logic [2:0] lcnt_r, lcnt_nxt;
	logic [15:0] timer_r, timer_nxt;
	logic restart_r, restart_nxt;
	logic air_fault_r, air_fault_nxt;
	logic air_mon_r;
	logic lockout_r, lockout_nxt, chain_wait_r, chain_wait_nxt, air_check_r, air_check_nxt;
	logic air_mon;
	logic ev_lock, ev_chain;
	logic can_restart;
	logic unlock_sw, unlock_pulse;

	brlp_air_mask u_air_mask (
		.seq_state_i(seq_state_i),
		.mask_i(air_pressure_monitor_mask_r),
		.monitor_o(air_mon)
	);

	assign unlock_pulse = unlock_i | unlock_sw;
	assign can_restart = (rcnt_r < restart_limit_r) && (lcnt_r < liftoff_restart_limit_r);

	always_comb begin
		state_nxt = state_r;
		rcnt_nxt = rcnt_r;
		lcnt_nxt = lcnt_r;
		timer_nxt = timer_r;
		restart_nxt = 1'h0;
		ev_lock = 1'h0;
		ev_chain = 1'h0;
		air_fault_nxt = air_mon && !air_ok;
		case (state_r)
			ST_RUN: begin
				if (!chain_ok) begin
					state_nxt = ST_CHAIN_WAIT; // see RULE_04, see RULE_07
					timer_nxt = chain_open_timeout_r; // see RULE_13
					ev_chain = 1'h1;
				end else if (liftoff_i) begin
					if (can_restart) begin
						state_nxt = ST_AIR_CHECK; // see RULE_01, see RULE_03
						timer_nxt = `BRLP_AIR_CHECK_TICKS;
						rcnt_nxt = rcnt_r + 3'h1;
						lcnt_nxt = lcnt_r + 3'h1;
					end else if (!flame_ok) begin
						state_nxt = ST_LOCKOUT; // see RULE_03, see RULE_12
						ev_lock = 1'h1;
					end
				end
			end
			ST_CHAIN_WAIT: begin
				if (chain_ok) begin
					state_nxt = ST_RUN;
				end else if (timer_r == 16'h0000) begin
					if (open_chain_policy_r == `BRLP_POLICY_LOCK || restart_limit_r == 3'h0 ||
						rcnt_r >= restart_limit_r) begin
						state_nxt = ST_LOCKOUT; // see RULE_05, see RULE_06, see RULE_08
						ev_lock = 1'h1;
					end else begin
						state_nxt = ST_RUN; // see RULE_05, see RULE_06
						rcnt_nxt = rcnt_r + 3'h1;
						restart_nxt = 1'h1;
					end
				end else if (tick_r) begin
					timer_nxt = timer_r - 16'h0001; // see RULE_13
				end
			end
			ST_AIR_CHECK: begin
				if (timer_r == 16'h0000) begin
					if (!air_ok) begin
						state_nxt = ST_RUN; // see RULE_03
						restart_nxt = 1'h1;
					end else if (can_restart) begin
						timer_nxt = `BRLP_AIR_CHECK_TICKS; // see RULE_03
						rcnt_nxt = rcnt_r + 3'h1;
						lcnt_nxt = lcnt_r + 3'h1;
					end else begin
						state_nxt = ST_LOCKOUT; // see RULE_12
						ev_lock = 1'h1;
					end
				end else if (tick_r) begin
					timer_nxt = timer_r - 16'h0001;
				end
			end
			ST_LOCKOUT: begin
				state_nxt = ST_LOCKOUT; // see RULE_12
			end
			default: begin
				state_nxt = ST_LOCKOUT;
			end
		endcase
		if (unlock_pulse) begin
			rcnt_nxt = 3'h0; // see RULE_02
			lcnt_nxt = 3'h0;
			if (state_r == ST_LOCKOUT) begin
				state_nxt = ST_RUN;
			end
		end else if (enter_operating_i) begin
			rcnt_nxt = 3'h0; // see RULE_02
			lcnt_nxt = 3'h0;
		end
		lockout_nxt = (state_nxt == ST_LOCKOUT);
		chain_wait_nxt = (state_nxt == ST_CHAIN_WAIT);
		air_check_nxt = (state_nxt == ST_AIR_CHECK);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_RUN;
			rcnt_r <= 3'h0;
			lcnt_r <= 3'h0;
			timer_r <= 16'h0000;
			restart_r <= 1'h0;
			air_fault_r <= 1'h0;
			air_mon_r <= 1'h0;
			lockout_r <= 1'h0;
			chain_wait_r <= 1'h0;
			air_check_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			rcnt_r <= rcnt_nxt;
			lcnt_r <= lcnt_nxt;
			timer_r <= timer_nxt;
			restart_r <= restart_nxt;
			air_fault_r <= air_fault_nxt;
			air_mon_r <= air_mon; // see RULE_09, see RULE_10
			lockout_r <= lockout_nxt;
			chain_wait_r <= chain_wait_nxt;
			air_check_r <= air_check_nxt;
		end
	end

	// apb slave, one wait state
	logic acc;
	logic wr;
	always_comb begin
		restart_limit_nxt = restart_limit_r;
		liftoff_restart_limit_nxt = liftoff_restart_limit_r;
		open_chain_policy_nxt = open_chain_policy_r;
		air_pressure_monitor_mask_nxt = air_pressure_monitor_mask_r;
		chain_open_timeout_nxt = chain_open_timeout_r;
		irq_en_nxt = irq_en_r;
		irq_stat_nxt = irq_stat_r;
		unlock_sw = 1'h0;
		acc = psel_i && penable_i && pready_r;
		wr = acc && pwrite_i && !pslverr_r;
		pready_nxt = psel_i && penable_i && !pready_r;
		pslverr_nxt = 1'h0;
		prdata_nxt = prdata_r;
		if (pready_nxt) begin
			prdata_nxt = 32'h00000000;
			case (paddr_i)
				`BRLP_OFF_CTRL: begin
					prdata_nxt[`BRLP_CTRL_RLIM] = restart_limit_r;
					prdata_nxt[`BRLP_CTRL_LLIM] = liftoff_restart_limit_r;
					prdata_nxt[`BRLP_CTRL_POLICY] = open_chain_policy_r;
				end
				`BRLP_OFF_AIRMASK: prdata_nxt[5:0] = air_pressure_monitor_mask_r;
				`BRLP_OFF_TIMEOUT: prdata_nxt[15:0] = chain_open_timeout_r;
				`BRLP_OFF_STATUS: prdata_nxt[9:0] = {air_fault_r, air_mon_r, state_r, lcnt_r, rcnt_r};
				`BRLP_OFF_IRQ_STAT: prdata_nxt[3:0] = irq_stat_r;
				`BRLP_OFF_IRQ_EN: prdata_nxt[3:0] = irq_en_r;
				`BRLP_OFF_IRQ_CLR, `BRLP_OFF_CMD: prdata_nxt = 32'h00000000;
				default: pslverr_nxt = 1'h1;
			endcase
		end
		if (wr) begin
			case (paddr_i)
				`BRLP_OFF_CTRL: begin
					restart_limit_nxt = (pwdata_i[`BRLP_CTRL_RLIM] > `BRLP_LIMIT_MAX) ?
						`BRLP_LIMIT_MAX : pwdata_i[`BRLP_CTRL_RLIM]; // see RULE_12
					liftoff_restart_limit_nxt = (pwdata_i[`BRLP_CTRL_LLIM] > `BRLP_LIMIT_MAX) ?
						`BRLP_LIMIT_MAX : pwdata_i[`BRLP_CTRL_LLIM]; // see RULE_01
					open_chain_policy_nxt = pwdata_i[`BRLP_CTRL_POLICY];
				end
				`BRLP_OFF_AIRMASK: air_pressure_monitor_mask_nxt = pwdata_i[5:0];
				`BRLP_OFF_TIMEOUT: chain_open_timeout_nxt = pwdata_i[15:0];
				`BRLP_OFF_IRQ_CLR: irq_stat_nxt = irq_stat_r & ~pwdata_i[3:0];
				`BRLP_OFF_IRQ_EN: irq_en_nxt = pwdata_i[3:0];
				`BRLP_OFF_CMD: unlock_sw = pwdata_i[`BRLP_CMD_UNLOCK]; // see RULE_02
				default: unlock_sw = 1'h0;
			endcase
		end
		// set wins over clear
		irq_stat_nxt[`BRLP_IRQ_LOCK] = irq_stat_nxt[`BRLP_IRQ_LOCK] | ev_lock;
		irq_stat_nxt[`BRLP_IRQ_RESTART] = irq_stat_nxt[`BRLP_IRQ_RESTART] | restart_nxt;
		irq_stat_nxt[`BRLP_IRQ_CHAIN] = irq_stat_nxt[`BRLP_IRQ_CHAIN] | ev_chain;
		irq_stat_nxt[`BRLP_IRQ_AIR] = irq_stat_nxt[`BRLP_IRQ_AIR] | (air_fault_nxt & ~air_fault_r);
		irq_nxt = |(irq_stat_nxt & irq_en_nxt);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			restart_limit_r <= `BRLP_RST_LIMIT;
			liftoff_restart_limit_r <= `BRLP_RST_LIMIT;
			open_chain_policy_r <= `BRLP_RST_POLICY;
			air_pressure_monitor_mask_r <= `BRLP_RST_AIRMASK;
			chain_open_timeout_r <= `BRLP_RST_TIMEOUT;
			irq_stat_r <= 4'h0;
			irq_en_r <= 4'h0;
			prdata_r <= 32'h00000000;
			pready_r <= 1'h0;
			pslverr_r <= 1'h0;
			irq_r <= 1'h0;
		end else begin
			restart_limit_r <= restart_limit_nxt;
			liftoff_restart_limit_r <= liftoff_restart_limit_nxt;
			open_chain_policy_r <= open_chain_policy_nxt;
			air_pressure_monitor_mask_r <= air_pressure_monitor_mask_nxt;
			chain_open_timeout_r <= chain_open_timeout_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_en_r <= irq_en_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign restart_req_o = restart_r;
	assign lockout_o = lockout_r;
	assign chain_wait_o = chain_wait_r;
	assign air_check_o = air_check_r;
	assign air_monitor_o = air_mon_r;
	assign air_fault_o = air_fault_r;
	assign irq_o = irq_r;

	// checks
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_liftoff_cap: assert property ((state_r == ST_RUN) && chain_ok && liftoff_i && !unlock_pulse && // see RULE_01
		(lcnt_r >= liftoff_restart_limit_r) && !flame_ok |=> lockout_o)
		else $error("lift-off beyond limit did not lock out");
	a_count_clear: assert property (enter_operating_i || unlock_pulse |=> rcnt_r == 3'h0 && lcnt_r == 3'h0) // see RULE_02
		else $error("counters not cleared");
	a_air_between: assert property ((state_r == ST_RUN) && chain_ok && liftoff_i && can_restart && // see RULE_03
		!unlock_pulse |=> air_check_o ##1 (air_check_o || restart_req_o || lockout_o))
		else $error("no idle air check between restarts");
	a_chain_hold: assert property ((state_r == ST_RUN) && !chain_ok |=> chain_wait_o) // see RULE_04
		else $error("open chain not held in wait");
	a_policy_lock: assert property ((state_r == ST_CHAIN_WAIT) && !chain_ok && timer_r == 16'h0000 && // see RULE_06
		open_chain_policy_r && !unlock_pulse |=> lockout_o && !restart_req_o)
		else $error("lockout policy not applied");
	a_chain_restart: assert property ((state_r == ST_CHAIN_WAIT) && !chain_ok && timer_r == 16'h0000 && // see RULE_05
		!open_chain_policy_r && rcnt_r < restart_limit_r && !unlock_pulse && !enter_operating_i
		|=> restart_req_o && rcnt_r == $past(rcnt_r) + 3'h1)
		else $error("counted restart not issued");
	a_zero_limit: assert property ((state_r == ST_CHAIN_WAIT) && restart_limit_r == 3'h0 |=> !restart_req_o) // see RULE_08
		else $error("restart with zero limit");
	a_wait_time: assert property ((state_r == ST_CHAIN_WAIT) && !chain_ok && timer_r != 16'h0000 // see RULE_13
		|=> chain_wait_o && !restart_req_o)
		else $error("chain wait left before timeout");
	a_air_idle: assert property (seq_state_i == `BRLP_SEQ_IDLE_CTRL && air_pressure_monitor_mask_r[0] // see RULE_10
		|=> air_monitor_o)
		else $error("idle air monitoring missing");
	a_air_start: assert property (seq_state_i >= `BRLP_SEQ_START_LO && seq_state_i <= `BRLP_SEQ_START_HI && // see RULE_09
		air_pressure_monitor_mask_r[3] |=> air_monitor_o)
		else $error("start-up air monitoring missing");
	a_lock_hold: assert property (lockout_o && !unlock_pulse |=> lockout_o) // see RULE_12
		else $error("lockout released without unlock");

endmodule
`default_nettype wire

//--- brlp_regs.svh
`ifndef BRLP_REGS_SVH
`define BRLP_REGS_SVH

// apb byte offsets
`define BRLP_OFF_CTRL 8'h00
`define BRLP_OFF_AIRMASK 8'h04
`define BRLP_OFF_TIMEOUT 8'h08
`define BRLP_OFF_STATUS 8'h0C
`define BRLP_OFF_IRQ_STAT 8'h10
`define BRLP_OFF_IRQ_CLR 8'h14
`define BRLP_OFF_IRQ_EN 8'h18
`define BRLP_OFF_CMD 8'h1C

// ctrl and cmd fields
`define BRLP_CTRL_RLIM 2:0
`define BRLP_CTRL_LLIM 6:4
`define BRLP_CTRL_POLICY 8
`define BRLP_CMD_UNLOCK 0

// reset values and limits
`define BRLP_RST_LIMIT 3'h5
`define BRLP_RST_POLICY 1'h1
`define BRLP_RST_AIRMASK 6'h3F
`define BRLP_RST_TIMEOUT 16'h000A
`define BRLP_RST_PINS 3'h1
`define BRLP_LIMIT_MAX 3'h5
`define BRLP_POLICY_LOCK 1'h1

// interrupt bits
`define BRLP_IRQ_LOCK 0
`define BRLP_IRQ_RESTART 1
`define BRLP_IRQ_CHAIN 2
`define BRLP_IRQ_AIR 3

// sequence state numbers
`define BRLP_SEQ_IDLE_CTRL 5'h03
`define BRLP_SEQ_START_LO 5'h06
`define BRLP_SEQ_START_HI 5'h0A
`define BRLP_SEQ_PILOT_LO 5'h0D
`define BRLP_SEQ_PILOT_HI 5'h0E
`define BRLP_SEQ_MAIN_LO 5'h11
`define BRLP_SEQ_MAIN_HI 5'h14
`define BRLP_SEQ_POSTAIR 5'h15
`define BRLP_SEQ_COOLING 5'h16
`define BRLP_SEQ_CHAIN_OPEN 5'h19

// timing
`define BRLP_CLK_NS 20
`define BRLP_TICK_MS 1000
`define BRLP_AIR_CHECK_TICKS 16'h0002

`endif

//--- brlp_pkg.sv
package brlp_pkg;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_CHAIN_WAIT,
		ST_AIR_CHECK,
		ST_LOCKOUT
	} brlp_state_t;

endpackage

//--- brlp_air_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "brlp_regs.svh"

module brlp_air_mask (
	// sequence and mask
	input wire logic [4:0] seq_state_i,
	input wire logic [5:0] mask_i,
	// result
	output logic monitor_o
);

	localparam logic [4:0] LO [6] = '{`BRLP_SEQ_IDLE_CTRL, `BRLP_SEQ_PILOT_LO, `BRLP_SEQ_MAIN_LO,
		`BRLP_SEQ_START_LO, `BRLP_SEQ_POSTAIR, `BRLP_SEQ_COOLING};
	localparam logic [4:0] HI [6] = '{`BRLP_SEQ_IDLE_CTRL, `BRLP_SEQ_PILOT_HI, `BRLP_SEQ_MAIN_HI,
		`BRLP_SEQ_START_HI, `BRLP_SEQ_POSTAIR, `BRLP_SEQ_COOLING};

	logic [5:0] hit;

	// one mask bit per phase window
	for (genvar i = 0; i < 6; i++) begin : g_phase
		assign hit[i] = mask_i[i] && (seq_state_i >= LO[i]) && (seq_state_i <= HI[i]); // see RULE_11
	end

	assign monitor_o = |hit;

endmodule
`default_nettype wire

//--- brlp_field_model.sv
`timescale 1ns/1ps
`default_nettype none

module brlp_field_model #(
	parameter int LAG = 1
) (
	// clock
	input wire logic sys_clk_i,
	// bench commands
	input wire logic chain_cmd_i,
	input wire logic flame_cmd_i,
	input wire logic air_cmd_i,
	// field pins
	output logic chain_closed_o,
	output logic flame_o,
	output logic air_pressure_switch_o
);
	// contacts settle lag cycles after a command, so a slow field can be modelled
	logic [2:0] pipe_r [LAG];
	always_ff @(posedge sys_clk_i) begin
		pipe_r[0] <= {chain_cmd_i, flame_cmd_i, air_cmd_i};
		for (int i = 1; i < LAG; i++) begin
			pipe_r[i] <= pipe_r[i - 1];
		end
	end
	assign {chain_closed_o, flame_o, air_pressure_switch_o} = pipe_r[LAG - 1];
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "brlp_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
`define WAIT_HI(s, n) begin k = 0; while ((s) !== 1'h1 && k < (n)) begin @(posedge sys_clk); k++; end `CHK(s, 1'h1) end

module tb_top;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pwrite = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic [4:0] seq_state = 5'h00;
	logic [2:0] ev = 3'h0;
	logic chain_cmd = 1'h1;
	logic flame_cmd = 1'h0;
	logic air_cmd = 1'h0;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, rerr, chain_closed, flame, air_sw;
	logic restart_req, lockout, chain_wait, air_check, air_monitor, air_fault, irq;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int n_restart = 0;
	int k, r0;
	logic [4:0] st [6] = '{5'h03, 5'h0E, 5'h14, 5'h06, 5'h15, 5'h16};

	always #10 sys_clk = ~sys_clk;

	brlp_top #(.TICK_CYCLES(4)) brlp_top_i (.sys_clk_i(sys_clk), .rst_i(rst), .paddr_i(paddr),
		.pwdata_i(pwdata), .pwrite_i(pwrite), .psel_i(psel), .penable_i(penable), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .seq_state_i(seq_state), .liftoff_i(ev[0]),
		.enter_operating_i(ev[1]), .unlock_i(ev[2]), .chain_closed_i(chain_closed), .flame_i(flame),
		.air_pressure_switch_i(air_sw), .restart_req_o(restart_req), .lockout_o(lockout),
		.chain_wait_o(chain_wait), .air_check_o(air_check), .air_monitor_o(air_monitor),
		.air_fault_o(air_fault), .irq_o(irq));

	brlp_field_model #(.LAG(2)) brlp_field_model_i (.sys_clk_i(sys_clk), .chain_cmd_i(chain_cmd),
		.flame_cmd_i(flame_cmd), .air_cmd_i(air_cmd), .chain_closed_o(chain_closed), .flame_o(flame),
		.air_pressure_switch_o(air_sw));

	task test_done;
		$display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (restart_req === 1'h1) begin
			n_restart++;
		end
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(rdata, e)
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task kick(input int b);
		@(posedge sys_clk);
		ev[b] <= 1'h1;
		@(posedge sys_clk);
		ev[b] <= 1'h0;
	endtask

	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		// reset values, saturation and unmapped access
		rd(`BRLP_OFF_CTRL, 32'h155);
		rd(`BRLP_OFF_AIRMASK, 32'h3F);
		rd(`BRLP_OFF_TIMEOUT, 32'h000A);
		rd(`BRLP_OFF_STATUS, 32'h0);
		wr(`BRLP_OFF_CTRL, 32'h177);
		rd(`BRLP_OFF_CTRL, 32'h155);
		rd(8'h20, 32'h0);
		`CHK(rerr, 1'h1)
		$display("test registers done");
		// each mask bit against its sequence range
		for (int i = 0; i < 6; i++) begin
			wr(`BRLP_OFF_AIRMASK, 32'h1 << i);
			seq_state <= st[i];
			settle(3);
			`CHK(air_monitor, 1'h1)
			`CHK(air_fault, 1'h1)
			wr(`BRLP_OFF_AIRMASK, 32'h3F ^ (32'h1 << i));
			settle(3);
			`CHK(air_monitor, 1'h0)
		end
		wr(`BRLP_OFF_AIRMASK, 32'h3F);
		seq_state <= 5'h0B;
		settle(3);
		`CHK(air_monitor, 1'h0)
		@(posedge sys_clk);
		seq_state <= 5'h00;
		$display("test air mask done");
		// lift-off restarts with idle air check, then exhaustion
		wr(`BRLP_OFF_CTRL, 32'h025);
		for (int i = 1; i < 3; i++) begin
			kick(0);
			@(negedge sys_clk);
			`CHK(air_check, 1'h1)
			`WAIT_HI(restart_req, 40)
			rd(`BRLP_OFF_STATUS, 32'h9 * i);
		end
		kick(0);
		`WAIT_HI(lockout, 5)
		rd(`BRLP_OFF_STATUS, 32'hD2);
		kick(2);
		settle(1);
		`CHK(lockout, 1'h0)
		rd(`BRLP_OFF_STATUS, 32'h0);
		kick(0);
		`WAIT_HI(restart_req, 40)
		rd(`BRLP_OFF_STATUS, 32'h9);
		kick(1);
		rd(`BRLP_OFF_STATUS, 32'h0);
		$display("test liftoff done");
		// failed idle air check, interrupt raise, clear and mask
		wr(`BRLP_OFF_IRQ_CLR, 32'hF);
		wr(`BRLP_OFF_IRQ_EN, 32'h1);
		wr(`BRLP_OFF_CTRL, 32'h015);
		air_cmd <= 1'h1;
		r0 = n_restart;
		kick(0);
		`WAIT_HI(lockout, 40)
		`CHK(n_restart, r0)
		settle(1);
		`CHK(irq, 1'h1)
		rd(`BRLP_OFF_IRQ_STAT, 32'h1);
		wr(`BRLP_OFF_IRQ_CLR, 32'h1);
		settle(2);
		`CHK(irq, 1'h0)
		wr(`BRLP_OFF_CMD, 32'h1);
		settle(2);
		`CHK(lockout, 1'h0)
		air_cmd <= 1'h0;
		wr(`BRLP_OFF_IRQ_EN, 32'h0);
		wr(`BRLP_OFF_CTRL, 32'h005);
		flame_cmd <= 1'h1;
		settle(4);
		kick(0);
		settle(1);
		`CHK(lockout, 1'h0)
		flame_cmd <= 1'h0;
		settle(4);
		kick(0);
		`WAIT_HI(lockout, 5)
		settle(1);
		`CHK(irq, 1'h0)
		rd(`BRLP_OFF_IRQ_STAT, 32'h1);
		kick(2);
		$display("test air check done");
		// open chain, immediate lockout policy
		wr(`BRLP_OFF_TIMEOUT, 32'h2);
		wr(`BRLP_OFF_CTRL, 32'h155);
		seq_state <= 5'h05;
		chain_cmd <= 1'h0;
		`WAIT_HI(chain_wait, 10)
		settle(2);
		`CHK(lockout, 1'h0)
		`WAIT_HI(lockout, 40)
		settle(0);
		`CHK(chain_wait, 1'h0)
		chain_cmd <= 1'h1;
		settle(6);
		kick(2);
		$display("test policy lock done");
		// counted restart, then lockout once the count is used
		wr(`BRLP_OFF_CTRL, 32'h051);
		chain_cmd <= 1'h0;
		`WAIT_HI(restart_req, 40)
		rd(`BRLP_OFF_STATUS, 32'h41);
		`WAIT_HI(lockout, 40)
		chain_cmd <= 1'h1;
		settle(6);
		kick(2);
		rd(`BRLP_OFF_STATUS, 32'h0);
		// zero restart limit overrides restart policy
		wr(`BRLP_OFF_CTRL, 32'h050);
		r0 = n_restart;
		chain_cmd <= 1'h0;
		`WAIT_HI(lockout, 40)
		`CHK(n_restart, r0)
		chain_cmd <= 1'h1;
		$display("test policy restart done");
		test_done();
	end
endmodule

`default_nettype wire
